// [scan_pkg.sv]
// Package for the scan test port controller: states, lengths, reset values.
// Assumes one system clock; the test clock arrives as a sampled pin.
package scan_pkg;

  // ---------------------------------------------------------------
  // Register lengths and reset values
  // ---------------------------------------------------------------
  localparam int          IR_LEN        = 8;
  localparam int          BSR_LEN       = 48;
  localparam int          BCR_LEN       = 3;
  localparam int          ID_LEN        = 32;
  localparam logic [7:0]  IR_RESET      = 8'h81;
  localparam logic [7:0]  IR_CAPTURE    = 8'h81;
  localparam logic [2:0]  BCR_RESET     = 3'h2;
  localparam logic [3:0]  BSR_OE_RESET  = 4'hF;
  localparam int          BSR_OE_LO     = 44;
  localparam logic [31:0] ID_VALUE      = 32'h0000_1001; // Arbitrary value

  // ---------------------------------------------------------------
  // Instruction opcodes (bit 7 even parity)
  // ---------------------------------------------------------------
  localparam logic [7:0]  OP_EXTEST     = 8'h00;
  localparam logic [7:0]  OP_IDCODE     = 8'h81;
  localparam logic [7:0]  OP_SAMPLE     = 8'h82;
  localparam logic [7:0]  OP_BCR_SCAN   = 8'h87;
  localparam logic [7:0]  OP_BYPASS     = 8'hFF;

  // Controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
    ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // Selected data register
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_BSR, SEL_BCR, SEL_ID
  } dr_sel_t;

  // Test bus pins as sampled
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } test_pins_t;

  // Edge events of the test clock
  typedef struct packed {
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
  } tck_event_t;

endpackage : scan_pkg

// [pin_sampler.sv]
// Samples the test bus pins into the system clock domain, finds edges.
// Assumes test clock well below a quarter of the system clock.
module pin_sampler
  import scan_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Raw pins
  input  wire test_pins_t pins,
  // Edge events
  output tck_event_t      ev
);

  typedef struct packed {
    test_pins_t s1;
    test_pins_t s2;
    test_pins_t s3;
    logic       tck_last;
    tck_event_t ev;
  } samp_state_t;

  samp_state_t st_q, st_d;

  // ---------------------------------------------------------------
  // Three stage sampling, edge accepted when stages two and three agree
  // ---------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    st_d.s1       = pins;
    st_d.s2       = st_q.s1;
    st_d.s3       = st_q.s2;
    st_d.ev       = '0;
    st_d.ev.tms   = st_q.s3.tms;
    st_d.ev.tdi   = st_q.s3.tdi;
    if (st_q.s2.tck == st_q.s3.tck && st_q.s3.tck != st_q.tck_last) begin
      st_d.tck_last = st_q.s3.tck;
      st_d.ev.rise  = st_q.s3.tck;  // Rising edge: sample inputs
      st_d.ev.fall  = !st_q.s3.tck; // Falling edge: change outputs
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ev = st_q.ev;

endmodule : pin_sampler

// [tap_fsm.sv]
// Next-state logic of the sixteen-state test port controller.
// Assumes the caller registers the state on rising test-clock events.
module tap_fsm
  import scan_pkg::*;
(
  // Present state and mode select
  input  wire tap_state_t cur,
  input  wire logic       tms,
  // Next state
  output tap_state_t      nxt
);

  // ---------------------------------------------------------------
  // Standard state graph
  // ---------------------------------------------------------------
  always_comb begin
    case (cur)
      ST_RESET:    nxt = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     nxt = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   nxt = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: nxt = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: nxt = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: nxt = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   nxt = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   nxt = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: nxt = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: nxt = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: nxt = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   nxt = tms ? ST_SEL_DR   : ST_IDLE;
      default:     nxt = ST_RESET;
    endcase
  end

endmodule : tap_fsm

// [scan_tap.sv]
// Test access port controller with instruction and data registers.
// Assumes test pins asynchronous to clock; test clock well below clock/4.
module scan_tap
  import scan_pkg::*;
#(
  parameter int          IRW = IR_LEN,
  parameter int          BSW = BSR_LEN,
  parameter logic [31:0] ID  = ID_VALUE // Arbitrary value
)(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Test bus pins
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  output logic                  tdo,
  output logic                  tdo_oe,
  // Device boundary
  input  wire logic [BSW-1:0]   pin_capture,
  output logic [BSW-1:0]        bsr_drive,
  output logic                  test_mode,
  output logic [BCR_LEN-1:0]    test_operation,
  output logic                  test_run
);

  typedef struct packed {
    tap_state_t         state;
    logic [IRW-1:0]     ir_shift;
    logic [IRW-1:0]     ir_cur;
    logic               bypass;
    logic [BSW-1:0]     bsr_shift;
    logic [BSW-1:0]     bsr_shadow;
    logic [BCR_LEN-1:0] bcr_shift;
    logic [BCR_LEN-1:0] bcr_shadow;
    logic [ID_LEN-1:0]  id_shift;
    logic               tdo;
    logic               tdo_oe;
    logic               test_mode;
    logic               test_run;
  } tap_regs_t;

  tap_regs_t  r_q, r_d;
  tck_event_t ev;
  tap_state_t fsm_next;
  test_pins_t pins;

  // ---------------------------------------------------------------
  // Pin sampling and state graph
  // ---------------------------------------------------------------
  assign pins = '{tck: tck, tms: tms, tdi: tdi};

  pin_sampler u_sampler (
    .clock (clock),
    .reset (reset),
    .pins  (pins),
    .ev    (ev)
  );

  tap_fsm u_fsm (
    .cur (r_q.state),
    .tms (ev.tms),
    .nxt (fsm_next)
  );

  // Data register selected by an instruction
  function automatic dr_sel_t decode_sel(input logic [IRW-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE: decode_sel = SEL_BSR;
      OP_IDCODE:            decode_sel = SEL_ID;
      OP_BCR_SCAN:          decode_sel = SEL_BCR;
      default:              decode_sel = SEL_BYPASS;
    endcase
  endfunction : decode_sel

  // Instructions that inhibit normal function
  function automatic logic is_test_op(input logic [IRW-1:0] op);
    is_test_op = (op == OP_EXTEST);
  endfunction : is_test_op

  dr_sel_t sel;
  assign sel = decode_sel(r_q.ir_cur);

  // ---------------------------------------------------------------
  // Register behaviour on test-clock events
  // ---------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    if (ev.rise) begin
      r_d.state = fsm_next;
      case (r_q.state)
        ST_CAP_DR: begin
          case (sel)
            SEL_BSR:    r_d.bsr_shift = pin_capture;
            SEL_BCR:    r_d.bcr_shift = r_q.bcr_shadow;
            SEL_ID:     r_d.id_shift  = ID;
            default:    r_d.bypass    = 1'b0;
          endcase
        end
        ST_SHIFT_DR: begin
          case (sel)
            SEL_BSR:    r_d.bsr_shift = {ev.tdi, r_q.bsr_shift[BSW-1:1]};
            SEL_BCR:    r_d.bcr_shift = {ev.tdi, r_q.bcr_shift[BCR_LEN-1:1]};
            SEL_ID:     r_d.id_shift  = {ev.tdi, r_q.id_shift[ID_LEN-1:1]};
            default:    r_d.bypass    = ev.tdi;
          endcase
        end
        ST_CAP_IR:   r_d.ir_shift = IR_CAPTURE;
        ST_SHIFT_IR: r_d.ir_shift = {ev.tdi, r_q.ir_shift[IRW-1:1]};
        // Select, exit and pause states hold all contents
        default: ;
      endcase
    end
    if (ev.fall) begin
      // Output driver follows the shift states
      case (r_q.state)
        ST_SHIFT_DR: begin
          r_d.tdo_oe = 1'b1;
          case (sel)
            SEL_BSR:    r_d.tdo = r_q.bsr_shift[0];
            SEL_BCR:    r_d.tdo = r_q.bcr_shift[0];
            SEL_ID:     r_d.tdo = r_q.id_shift[0];
            default:    r_d.tdo = r_q.bypass;
          endcase
        end
        ST_SHIFT_IR: begin
          r_d.tdo_oe = 1'b1;
          r_d.tdo    = r_q.ir_shift[0];
        end
        default: begin
          r_d.tdo_oe = 1'b0;
          r_d.tdo    = 1'b0;
        end
      endcase
      case (r_q.state)
        ST_RESET: begin
          r_d.ir_cur     = IR_RESET;
          r_d.ir_shift   = IR_RESET;
          r_d.bcr_shadow = BCR_RESET;
          r_d.bsr_shadow[BSR_OE_LO +: 4] = BSR_OE_RESET;
          r_d.test_mode  = 1'b0;
        end
        ST_UPD_DR: begin
          if (sel == SEL_BSR) r_d.bsr_shadow = r_q.bsr_shift;
          if (sel == SEL_BCR) r_d.bcr_shadow = r_q.bcr_shift;
        end
        ST_UPD_IR: begin
          r_d.ir_cur    = r_q.ir_shift;
          r_d.test_mode = is_test_op(r_q.ir_shift);
        end
        default: ;
      endcase
      r_d.test_run = (r_q.state == ST_IDLE);
    end
  end

  // State register; reset returns to the reset state
  always_ff @(posedge clock) begin
    if (reset) begin
      r_q            <= '0;
      r_q.state      <= ST_RESET;
      r_q.ir_shift   <= IR_RESET;
      r_q.ir_cur     <= IR_RESET;
      r_q.bcr_shadow <= BCR_RESET;
      r_q.bsr_shadow[BSR_OE_LO +: 4] <= BSR_OE_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flip-flops
  assign tdo            = r_q.tdo;
  assign tdo_oe         = r_q.tdo_oe;
  assign bsr_drive      = r_q.bsr_shadow;
  assign test_mode      = r_q.test_mode;
  assign test_operation = r_q.bcr_shadow;
  assign test_run       = r_q.test_run;

endmodule : scan_tap

// [scan_tap_checker.sv]
// Checker of the scan test port controller, watching its ports only.
// Assumes a test clock half period of ten system clocks.
module scan_tap_checker
  import scan_pkg::*;
#(
  parameter int          IRW = IR_LEN,
  parameter int          BSW = BSR_LEN,
  parameter logic [31:0] ID  = ID_VALUE
)(
  // Clock and reset
  input wire logic               clock,
  input wire logic               reset,
  // Test bus
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdi,
  input wire logic               tdo,
  input wire logic               tdo_oe,
  // Device boundary
  input wire logic [BSW-1:0]     pin_capture,
  input wire logic [BSW-1:0]     bsr_drive,
  input wire logic               test_mode,
  input wire logic [BCR_LEN-1:0] test_operation,
  input wire logic               test_run
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic       tck_q;
  logic [2:0] hi_q;

  // Count test clock rises with mode select high
  always_ff @(posedge clock) begin
    tck_q <= tck;
    if (reset) begin
      hi_q <= 3'h0;
    end else if (tck && !tck_q) begin
      hi_q <= !tms ? 3'h0 : (hi_q == 3'h7 ? hi_q : hi_q + 3'h1);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Test clock low for three samples
  sequence low3;
    !tck && !$past(tck) && !$past(tck, 2);
  endsequence
  // Outputs at their reset-state values
  sequence quiet;
    !tdo_oe && !test_run && !test_mode && test_operation == BCR_RESET;
  endsequence

  // Output timing and reset behaviour
  reset_state_a: assert property ($fell(reset) |-> !tdo_oe && !test_run && !test_mode
      && test_operation == BCR_RESET && bsr_drive[BSW-1 -: 4] == BSR_OE_RESET)
    else $error("outputs not at reset values");
  tdo_edge_a: assert property ($changed(tdo) |-> low3)
    else $error("tdo moved near a rising test clock");
  oe_edge_a: assert property ($changed(tdo_oe) |-> low3)
    else $error("tdo enable moved near a rising test clock");
  run_edge_a: assert property ($changed(test_run) |-> low3)
    else $error("run flag moved near a rising test clock");
  shadow_edge_a: assert property ($changed({test_mode, test_operation, bsr_drive}) |-> low3)
    else $error("shadow moved near a rising test clock");
  tdo_off_a: assert property (!tdo_oe |-> tdo == 1'b0)
    else $error("tdo not low while disabled");
  one_path_a: assert property (!(test_run && tdo_oe))
    else $error("idle and shift at once");
  tms_reset_a: assert property (hi_q >= 3'h5 && $fell(tck) |-> ##8 quiet)
    else $error("five high mode selects did not reset");
endmodule : scan_tap_checker

bind scan_tap scan_tap_checker #(.IRW(IRW), .BSW(BSW), .ID(ID)) checker_i (
  .clock(clock), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe), .pin_capture(pin_capture), .bsr_drive(bsr_drive),
  .test_mode(test_mode), .test_operation(test_operation), .test_run(test_run));

// [scan_host.sv]
// Model of the external test bus controller on the four-wire port.
// Assumes a 160 ns test clock that stands low between frames.
module scan_host
  import scan_pkg::*;
(
  // Test bus
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  logic q_bit;
  logic q_oe;
  logic oe_all;

  // Idle levels of the pulled-up lines
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock; tdo taken just before the rise
  task automatic pulse(input logic m, input logic d);
    tms = m;
    tdi = d;
    #80;
    q_bit = tdo;
    q_oe = tdo_oe;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask : pulse

  // Walk the states, mode select bits LSB first
  task automatic walk(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) pulse(m[i], 1'b1);
  endtask : walk

  // Shift n bits, mode select high on the last
  task automatic shift(input logic [63:0] d, input int n, output logic [63:0] q);
    q = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, d[i]);
      q[i] = q_bit;
      oe_all = oe_all & q_oe;
    end
  endtask : shift
endmodule : scan_host

// [scan_tap_test.sv]
// Self-checking bench of the scan test port controller.
// Assumes the host model drives the test bus at 160 ns per bit.
module scan_tap_test
  import scan_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  logic               clock, reset, tck, tms, tdi, tdo, tdo_oe, test_mode, test_run;
  logic [BSR_LEN-1:0] pin_capture, bsr_drive;
  logic [BCR_LEN-1:0] test_operation;
  logic [63:0]        q;
  int                 n_mismatch = 0;
  int                 compares = 0;
  int                 cycles = 0;

  scan_tap DUT (.clock(clock), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_capture(pin_capture), .bsr_drive(bsr_drive),
    .test_mode(test_mode), .test_operation(test_operation), .test_run(test_run));
  scan_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  // Clock and hang limit
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Let the fall-edge updates land
  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask : settle
  task automatic load_ir(input logic [7:0] op);
    host.walk(8'h03, 4);
    host.shift(64'(op), 8, q);
    host.walk(8'h01, 2);
    settle();
  endtask : load_ir
  task automatic scan_dr(input logic [63:0] d, input int n);
    host.walk(8'h01, 3);
    host.shift(d, n, q);
    host.walk(8'h01, 2);
    settle();
  endtask : scan_dr
  task automatic tms_reset();
    host.walk(8'h1F, 5);
    settle();
  endtask : tms_reset

  // Scenarios
  task automatic t_reset();
    check(tdo_oe, 1'b0);
    check(test_operation, BCR_RESET);
    check(bsr_drive[47:44], BSR_OE_RESET);
  endtask : t_reset
  task automatic t_ir();
    host.walk(8'h00, 1);
    settle();
    check(test_run, 1'b1);
    host.walk(8'h03, 4);
    host.shift(64'(OP_BYPASS), 8, q);
    check(q, IR_CAPTURE);
    check(host.oe_all, 1'b1);
    host.walk(8'h01, 1);
    check(host.q_oe, 1'b0);
    host.walk(8'h00, 1);
    scan_dr(64'hA5, 8);
    check(q, 64'h4A);
    load_ir(OP_BYPASS);
    check(q, IR_CAPTURE);
    tms_reset();
  endtask : t_ir
  task automatic t_id();
    host.walk(8'h00, 1);
    scan_dr(64'h0, 32);
    check(q, ID_VALUE);
  endtask : t_id
  task automatic t_bcr();
    load_ir(OP_BCR_SCAN);
    host.walk(8'h01, 3);
    host.shift(64'h3, 2, q);
    check(q[1:0], 2'b10);
    host.walk(8'h08, 5);
    host.shift(64'h5, 3, q);
    check(q[2:0], 3'b110);
    host.walk(8'h01, 2);
    settle();
    check(test_operation, 3'h5);
    tms_reset();
    check(test_operation, BCR_RESET);
  endtask : t_bcr
  task automatic t_extest();
    host.walk(8'h00, 1);
    pin_capture = 48'h9C3A_5E71_B2D4;
    load_ir(OP_EXTEST);
    check(test_mode, 1'b1);
    scan_dr(64'h0123_4567_89AB, 48);
    check(q, 64'h9C3A_5E71_B2D4);
    check(bsr_drive, 48'h0123_4567_89AB);
    tms_reset();
    check(test_mode, 1'b0);
    check(bsr_drive[47:44], BSR_OE_RESET);
    host.walk(8'h00, 1);
    load_ir(OP_SAMPLE);
    check(test_mode, 1'b0);
    pin_capture = 48'h3E5B_C18D_7A26;
    scan_dr(64'h0, 48);
    check(q, 64'h3E5B_C18D_7A26);
    check(bsr_drive, 48'h0);
  endtask : t_extest

  // Main sequence
  initial begin
    reset = 1'b1;
    pin_capture = '0;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    t_reset();
    t_ir();
    t_id();
    t_bcr();
    t_extest();
    conclude();
  end
endmodule : scan_tap_test
